// ### hfs_pkg.sv
// Constants, field layout and state type of the HDLC status and receive block.
// Assumes a 32-bit classic Wishbone bus with 16-bit registers in the low half.
package hfs_pkg;

    // ----------------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ----------------------------------------------------------------------
    localparam logic [7:0] IDX_TX_LIVE = 8'hA4;
    localparam logic [7:0] IDX_TX_LAT = 8'hA6;
    localparam logic [7:0] IDX_TX_EN = 8'hA8;
    localparam logic [7:0] IDX_RX_CTRL = 8'hB0;
    localparam logic [7:0] IDX_RX_LIVE = 8'hB4;
    localparam logic [7:0] IDX_RX_LAT = 8'hB6;
    localparam logic [7:0] IDX_RX_EN = 8'hB8;
    localparam logic [7:0] IDX_RX_DATA = 8'hBC;
    localparam logic [7:0] IDX_GATE = 8'hF0;

    // ----------------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------------
    localparam int TX_OVF = 5;
    localparam int TX_UND = 4;
    localparam int TX_PEND = 3;
    localparam int TX_FULL = 2;
    localparam int TX_EMPTY = 1;
    localparam int TX_SPACE = 0;
    localparam int RX_OVF = 7;
    localparam int RX_PEND = 4;
    localparam int RX_PSTART = 3;
    localparam int RX_FULL = 2;
    localparam int RX_EMPTY = 1;
    localparam int RX_AVAIL = 0;
    localparam int CTL_THR_LSB = 8;
    localparam int CTL_SWAP = 3;
    localparam int CTL_INV = 2;
    localparam int CTL_NOFCS = 1;
    localparam int CTL_CLR = 0;
    localparam logic [15:0] TX_EVT_MASK = 16'h003F;
    localparam logic [15:0] RX_EVT_MASK = 16'h009D;

    // ----------------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------------
    localparam logic [15:0] EN_RST = 16'h0000;
    localparam logic [4:0] THR_RST = 5'h08;

    // ----------------------------------------------------------------------
    // Packet status codes and framing constants
    // ----------------------------------------------------------------------
    localparam logic [2:0] PS_MID = 3'h0;
    localparam logic [2:0] PS_START = 3'h1;
    localparam logic [2:0] PS_GOOD = 3'h4;
    localparam logic [2:0] PS_FCS = 3'h5;
    localparam logic [2:0] PS_INVALID = 3'h6;
    localparam logic [2:0] PS_ABORT = 3'h7;
    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    localparam logic [15:0] CRC_GOOD = 16'hF0B8;
    localparam logic [15:0] CRC_POLY = 16'h8408;
    localparam logic [2:0] STUFF_ONES = 3'h5;
    localparam logic [2:0] FLAG_ONES = 3'h6;
    localparam logic [2:0] FLAG_BITS = 3'h7;

    // ----------------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 5000;
    localparam int PWRUP_NS = 100;
    localparam int PWRUP_CYC = (PWRUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    typedef enum logic [1:0] {RX_OFF, RX_WAKE, RX_HUNT, RX_FRAME} hfs_rx_state_t;

endpackage

// ### hfs_ctrl.sv
// HDLC status, interrupt and receive control with receive deframer and FIFO.
// Assumes transmit events and the receive bit stream come from logic on ref_clk_in.
`timescale 1ns/1ps
module hfs_ctrl
    import hfs_pkg::*;
#(
    parameter int DEPTH = 256,
    parameter int AW = 8
) (
    input wire logic ref_clk_in,
    input wire logic resetn_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [9:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    input wire logic tx_overflow_in,
    input wire logic tx_underflow_in,
    input wire logic tx_packet_end_in,
    input wire logic tx_fifo_empty_live_in,
    input wire logic tx_space_avail_live_in,
    input wire logic tx_fifo_full_live_in,
    input wire logic tx_fifo_clear_in,
    input wire logic rx_bit_in,
    input wire logic rx_bit_en_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    output logic irq_out,
    output logic rx_fifo_power_down_out
);

    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c;
        for (int i = 0; i < 8; i++) begin
            r = (r[0] ^ d[i]) ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

    function automatic logic [7:0] rev8(input logic [7:0] d);
        logic [7:0] r;
        for (int i = 0; i < 8; i++) begin
            r[i] = d[7 - i];
        end
        return r;
    endfunction

    // ----------------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------------
    logic bus_req;
    logic wr;
    logic rd;
    logic [7:0] idx;
    logic [15:0] wdat;
    logic [15:0] bmask;
    assign bus_req = wb_cyc_in & wb_stb_in & ~wb_ack_out;
    assign wr = bus_req & wb_we_in;
    assign rd = bus_req & ~wb_we_in;
    assign idx = wb_adr_in[9:2];
    assign bmask = {{8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};
    assign wdat = wb_dat_in[15:0] & bmask;

    logic [15:0] tx_lat_q;
    logic [15:0] tx_en_q;
    logic [15:0] rx_lat_q;
    logic [15:0] rx_en_q;
    logic [15:0] ctrl_q;
    logic gate_q;
    logic [15:0] rdata;
    logic clr;
    logic [4:0] thr;
    assign clr = ctrl_q[CTL_CLR];
    assign thr = ctrl_q[CTL_THR_LSB +: 5];

    // ----------------------------------------------------------------------
    // Receive FIFO
    // ----------------------------------------------------------------------
    logic [10:0] mem [DEPTH];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0] cnt_q;
    logic rx_empty;
    logic rx_full;
    logic push;
    logic pop;
    logic wr_q;
    logic [10:0] wword_q;
    logic pstart_q;
    logic pend_q;
    logic avail_q;
    assign rx_empty = (cnt_q == '0);
    assign rx_full = (cnt_q == (AW + 1)'(DEPTH));
    assign push = wr_q & ~rx_full & ~clr;
    assign pop = rd & (idx == IDX_RX_DATA) & wb_sel_in[1] & ~rx_empty & ~clr;

    always_ff @(posedge ref_clk_in) begin
        if (push) begin
            mem[wp_q] <= wword_q;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in || clr) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else begin
            wp_q <= wp_q + AW'(push);
            rp_q <= rp_q + AW'(pop);
            cnt_q <= cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            avail_q <= 1'b0;
        end else begin
            avail_q <= ~clr && (cnt_q >= (AW + 1)'({thr, 3'h0}));
        end
    end

    // ----------------------------------------------------------------------
    // Receive deframer
    // ----------------------------------------------------------------------
    hfs_rx_state_t st_q;
    logic [2:0] ones_q;
    logic [2:0] bits_q;
    logic [7:0] sr_q;
    logic [15:0] crc_q;
    logic [7:0] hold_q;
    logic hold_v_q;
    logic hold_first_q;
    logic first_q;
    logic [15:0] pwr_q;
    logic b;
    logic data_bit;
    logic [7:0] sr_nxt;
    logic [2:0] end_st;
    assign b = rx_bit_in ^ ctrl_q[CTL_INV];
    assign data_bit = (st_q == RX_FRAME) && (b ? (ones_q < FLAG_ONES) : (ones_q < STUFF_ONES));
    assign sr_nxt = {b, sr_q[7:1]};
    always_comb begin
        if (bits_q != FLAG_BITS) begin
            end_st = PS_INVALID;
        end else if (!ctrl_q[CTL_NOFCS] && crc_q != CRC_GOOD) begin
            end_st = PS_FCS;
        end else begin
            end_st = PS_GOOD;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            st_q <= RX_OFF;
            ones_q <= '0;
            bits_q <= '0;
            sr_q <= '0;
            crc_q <= CRC_INIT;
            hold_q <= '0;
            hold_v_q <= 1'b0;
            hold_first_q <= 1'b0;
            first_q <= 1'b0;
            pwr_q <= '0;
            wr_q <= 1'b0;
            wword_q <= '0;
            pstart_q <= 1'b0;
            pend_q <= 1'b0;
        end else begin
            wr_q <= 1'b0;
            pend_q <= 1'b0;
            if (clr) begin
                st_q <= RX_OFF;
                hold_v_q <= 1'b0;
            end else begin
                case (st_q)
                    RX_OFF: begin
                        pwr_q <= '0;
                        st_q <= RX_WAKE;
                    end
                    RX_WAKE: begin
                        pwr_q <= pwr_q + 16'h0001;
                        if (pwr_q >= 16'(PWRUP_CYC - 1)) begin
                            ones_q <= '0;
                            st_q <= RX_HUNT;
                        end
                    end
                    RX_HUNT, RX_FRAME: begin
                        if (rx_bit_en_in) begin
                            if (b) begin
                                ones_q <= (ones_q == 3'h7) ? ones_q : ones_q + 3'h1;
                                if (ones_q == FLAG_ONES) begin
                                    if (st_q == RX_FRAME && hold_v_q) begin
                                        wr_q <= 1'b1;
                                        wword_q <= {hold_q, PS_ABORT};
                                        pstart_q <= hold_first_q;
                                        pend_q <= 1'b1;
                                    end
                                    hold_v_q <= 1'b0;
                                    st_q <= RX_HUNT;
                                end
                            end else begin
                                ones_q <= '0;
                                if (ones_q == FLAG_ONES) begin
                                    if (st_q == RX_FRAME && hold_v_q) begin
                                        wr_q <= 1'b1;
                                        wword_q <= {hold_q, end_st};
                                        pstart_q <= hold_first_q;
                                        pend_q <= 1'b1;
                                    end
                                    hold_v_q <= 1'b0;
                                    st_q <= RX_FRAME;
                                    bits_q <= '0;
                                    crc_q <= CRC_INIT;
                                    first_q <= 1'b1;
                                end
                            end
                            if (data_bit) begin
                                sr_q <= sr_nxt;
                                bits_q <= bits_q + 3'h1;
                                if (bits_q == 3'h7) begin
                                    crc_q <= crc_byte(crc_q, sr_nxt);
                                    if (hold_v_q) begin
                                        wr_q <= 1'b1;
                                        wword_q <= {hold_q, hold_first_q ? PS_START : PS_MID};
                                        pstart_q <= hold_first_q;
                                    end
                                    hold_q <= ctrl_q[CTL_SWAP] ? rev8(sr_nxt) : sr_nxt;
                                    hold_v_q <= 1'b1;
                                    hold_first_q <= first_q;
                                    first_q <= 1'b0;
                                end
                            end
                        end
                    end
                    default: st_q <= RX_OFF;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------------
    // Event edges
    // ----------------------------------------------------------------------
    logic tx_empty_p_q;
    logic tx_space_p_q;
    logic tx_full_p_q;
    logic tx_clr_p_q;
    logic rx_full_p_q;
    logic rx_avail_p_q;
    logic [15:0] tx_set;
    logic [15:0] rx_set;
    // Input history runs through reset, so a level high at release is no edge
    always_ff @(posedge ref_clk_in) begin
        tx_empty_p_q <= tx_fifo_empty_live_in;
        tx_space_p_q <= tx_space_avail_live_in;
        tx_full_p_q <= tx_fifo_full_live_in;
        tx_clr_p_q <= tx_fifo_clear_in;
    end

    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            rx_full_p_q <= 1'b0;
            rx_avail_p_q <= 1'b0;
        end else begin
            rx_full_p_q <= rx_full;
            rx_avail_p_q <= avail_q;
        end
    end

    always_comb begin
        tx_set = '0;
        tx_set[TX_OVF] = tx_overflow_in;
        tx_set[TX_UND] = tx_underflow_in;
        tx_set[TX_PEND] = tx_packet_end_in;
        tx_set[TX_FULL] = tx_fifo_full_live_in & ~tx_full_p_q;
        tx_set[TX_EMPTY] = (tx_fifo_empty_live_in & ~tx_empty_p_q) | (tx_clr_p_q & ~tx_fifo_clear_in);
        tx_set[TX_SPACE] = (tx_space_avail_live_in & ~tx_space_p_q) | (tx_clr_p_q & ~tx_fifo_clear_in);
        rx_set = '0;
        rx_set[RX_OVF] = wr_q & rx_full & ~clr;
        rx_set[RX_PEND] = push & pend_q;
        rx_set[RX_PSTART] = push & pstart_q;
        rx_set[RX_FULL] = rx_full & ~rx_full_p_q;
        rx_set[RX_AVAIL] = avail_q & ~rx_avail_p_q;
    end

    // ----------------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------------
    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            tx_lat_q <= '0;
            rx_lat_q <= '0;
        end else begin
            tx_lat_q <= ((tx_lat_q & ~((wr && idx == IDX_TX_LAT) ? wdat : 16'h0000)) | tx_set)
                & TX_EVT_MASK;
            rx_lat_q <= ((rx_lat_q & ~((wr && idx == IDX_RX_LAT) ? wdat : 16'h0000)) | rx_set)
                & RX_EVT_MASK;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            tx_en_q <= EN_RST;
            rx_en_q <= EN_RST;
            ctrl_q <= {3'h0, THR_RST, 8'h00};
            gate_q <= 1'b0;
        end else if (wr) begin
            if (idx == IDX_TX_EN) begin
                tx_en_q <= ((tx_en_q & ~bmask) | wdat) & TX_EVT_MASK;
            end
            if (idx == IDX_RX_EN) begin
                rx_en_q <= ((rx_en_q & ~bmask) | wdat) & RX_EVT_MASK;
            end
            if (idx == IDX_RX_CTRL) begin
                ctrl_q <= ((ctrl_q & ~bmask) | wdat) & 16'h1F0F;
            end
            if (idx == IDX_GATE && wb_sel_in[0]) begin
                gate_q <= wb_dat_in[0];
            end
        end
    end

    always_comb begin
        case (idx)
            IDX_TX_LIVE: rdata = {13'h0, tx_fifo_full_live_in, tx_fifo_empty_live_in,
                tx_space_avail_live_in};
            IDX_TX_LAT: rdata = tx_lat_q;
            IDX_TX_EN: rdata = tx_en_q;
            IDX_RX_CTRL: rdata = ctrl_q;
            IDX_RX_LIVE: rdata = {13'h0, rx_full, rx_empty, avail_q};
            IDX_RX_LAT: rdata = rx_lat_q;
            IDX_RX_EN: rdata = rx_en_q;
            IDX_RX_DATA: rdata = rx_empty ? 16'h0000 : {mem[rp_q][10:3], 4'h0, mem[rp_q][2:0], 1'b1};
            IDX_GATE: rdata = {15'h0, gate_q};
            default: rdata = 16'h0000;
        endcase
    end

    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            wb_ack_out <= 1'b0;
            wb_dat_out <= '0;
            irq_out <= 1'b0;
            rx_fifo_power_down_out <= 1'b0;
        end else begin
            wb_ack_out <= bus_req;
            wb_dat_out <= rd ? {16'h0000, rdata} : 32'h0000_0000;
            irq_out <= gate_q & (|(tx_lat_q & tx_en_q) | |(rx_lat_q & rx_en_q));
            rx_fifo_power_down_out <= clr;
        end
    end

    // ----------------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------------
    tx_overflow_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
        tx_overflow_in |=> tx_lat_q[TX_OVF]) else $error("overflow flag not set");
    tx_pkt_end_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
        tx_packet_end_in |=> tx_lat_q[TX_PEND]) else $error("packet end flag not set");
    tx_empty_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
        $rose(tx_fifo_empty_live_in) |=> tx_lat_q[TX_EMPTY]) else $error("empty flag missed");
    tx_clear_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
        $fell(tx_fifo_clear_in) |=> tx_lat_q[TX_EMPTY] && tx_lat_q[TX_SPACE])
        else $error("clear release flags missed");
    irq_gate_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
        irq_out |-> $past(gate_q)) else $error("interrupt without port gate");
    irq_full_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
        tx_lat_q[TX_FULL] && tx_en_q[TX_FULL] && gate_q |=> irq_out)
        else $error("full interrupt not raised");
    rx_avail_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
        ##1 avail_q == (!$past(clr) && $past(cnt_q) >= (AW + 1)'({$past(thr), 3'h0})))
        else $error("data available level wrong");
    rx_flush_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
        clr |=> cnt_q == '0 && !avail_q && rx_fifo_power_down_out)
        else $error("clear did not flush");
    rx_empty_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
        rd && idx == IDX_RX_LIVE |=> wb_ack_out && wb_dat_out[RX_EMPTY] == ($past(cnt_q) == '0))
        else $error("empty flag wrong");

endmodule

// ### hfs_bit_src.sv
// Serial source model for the receive bit stream of the HDLC block.
// Assumes the block samples the bit on the clock edge where the strobe is high.
`timescale 1ns/1ps
module hfs_bit_src (
    input wire logic clk_in,
    input wire logic invert_in,
    output logic bit_out,
    output logic en_out
);
    int ones = 0;

    initial begin
        bit_out = 1'b0;
        en_out = 1'b0;
    end

    // One bit every other cycle; between strobes the line shows the inverse
    task automatic put(input logic b);
        @(posedge clk_in);
        bit_out <= b ^ invert_in;
        en_out <= 1'b1;
        @(posedge clk_in);
        bit_out <= ~(b ^ invert_in);
        en_out <= 1'b0;
    endtask

    task automatic flag();
        put(1'b0);
        repeat (6) put(1'b1);
        put(1'b0);
        ones = 0;
    endtask

    // First bit on the line is the byte's LSB; a zero follows five ones
    task automatic byte_lsb(input logic [7:0] d);
        for (int i = 0; i < 8; i++) begin
            put(d[i]);
            ones = d[i] ? ones + 1 : 0;
            if (ones == 5) begin
                put(1'b0);
                ones = 0;
            end
        end
    endtask
endmodule

// ### tb_hfs_ctrl.sv
// Self-checking testbench for the HDLC status and receive block.
// Assumes hfs_pkg, hfs_ctrl and hfs_bit_src are compiled before it.
`timescale 1ns/1ps
module tb_hfs_ctrl
    import hfs_pkg::*;
;
    logic ref_clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, tclr = 1'b0, src_inv = 1'b0;
    logic [9:0] adr = 10'h000;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h00000000;
    logic [5:0] tev = 6'h00;
    logic [31:0] rdat;
    logic ack, irq, pd, src_bit, src_en;
    logic [15:0] ctl, dummy;
    logic [15:0] ctl_tab [4] = '{16'h0002, 16'h000A, 16'h0006, 16'h0000};
    int err_count = 0;
    int checks_done = 0;

    hfs_ctrl i_dut (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .wb_cyc_in(cyc),
        .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
        .tx_overflow_in(tev[5]), .tx_underflow_in(tev[4]), .tx_packet_end_in(tev[3]),
        .tx_fifo_full_live_in(tev[2]), .tx_fifo_empty_live_in(tev[1]),
        .tx_space_avail_live_in(tev[0]), .tx_fifo_clear_in(tclr), .rx_bit_in(src_bit),
        .rx_bit_en_in(src_en), .wb_dat_out(rdat), .wb_ack_out(ack), .irq_out(irq),
        .rx_fifo_power_down_out(pd));

    hfs_bit_src i_src (.clk_in(ref_clk_in), .invert_in(src_inv), .bit_out(src_bit),
        .en_out(src_en));

    initial begin
        forever #2.5 ref_clk_in = ~ref_clk_in;
    end

    // --------------------------------------------------------------------
    // Bus access, compare and closing tasks
    // --------------------------------------------------------------------
    task automatic bus(input logic w, input logic [7:0] idx, input logic [15:0] wd,
        output logic [15:0] rd);
        int n;
        @(posedge ref_clk_in);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        sel <= 4'h3;
        wdat <= {16'h0000, wd};
        n = 0;
        do begin
            @(posedge ref_clk_in);
            n++;
        end while (ack !== 1'b1 && n < 100);
        if (n >= 100) begin
            err_count++;
            $display("Error bus_ack expected 1 seen 0");
        end
        rd = rdat[15:0];
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] idx, input logic [15:0] d);
        bus(1'b1, idx, d, dummy);
    endtask

    task automatic rd_chk(input string nm, input logic [7:0] idx, input logic [15:0] e);
        logic [15:0] v;
        bus(1'b0, idx, 16'h0000, v);
        chk(nm, e, v);
    endtask

    task automatic irq_chk(input logic e);
        repeat (3) @(posedge ref_clk_in);
        chk("irq_out", {15'h0000, e}, {15'h0000, irq});
    endtask

    // Two flags, two bytes, closing flag
    task automatic frame();
        i_src.flag();
        i_src.flag();
        i_src.byte_lsb(8'h1C);
        i_src.byte_lsb(8'hF8);
        i_src.flag();
        repeat (4) @(posedge ref_clk_in);
    endtask

    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge ref_clk_in);
        err_count++;
        $display("Error watchdog expected done seen timeout");
        end_sim();
    end

    // --------------------------------------------------------------------
    // Test sequence
    // --------------------------------------------------------------------
    initial begin
        repeat (8) @(posedge ref_clk_in);
        resetn_in <= 1'b1;
        rd_chk("rx_control", IDX_RX_CTRL, 16'h0800);
        rd_chk("tx_enable", IDX_TX_EN, 16'h0000);
        rd_chk("rx_enable", IDX_RX_EN, 16'h0000);
        rd_chk("rx_live", IDX_RX_LIVE, 16'h0002);
        wr(8'h40, 16'hFFFF);
        rd_chk("unmapped", 8'h40, 16'h0000);
        for (int i = 0; i < 6; i++) begin
            tev <= 6'(1 << i);
            @(posedge ref_clk_in);
            tev <= 6'h00;
            rd_chk("tx_latch", IDX_TX_LAT, 16'(1 << i));
            wr(IDX_TX_LAT, 16'(1 << i));
            rd_chk("tx_latch_clr", IDX_TX_LAT, 16'h0000);
        end
        tev <= 6'h07;
        rd_chk("tx_live", IDX_TX_LIVE, 16'h0007);
        tev <= 6'h00;
        wr(IDX_TX_LAT, 16'h0007);
        rd_chk("tx_latch_lvl", IDX_TX_LAT, 16'h0000);
        tclr <= 1'b1;
        @(posedge ref_clk_in);
        tclr <= 1'b0;
        rd_chk("tx_latch_rel", IDX_TX_LAT, 16'h0003);
        wr(IDX_TX_LAT, 16'h0003);
        wr(IDX_GATE, 16'h0001);
        wr(IDX_TX_EN, 16'h0020);
        tev <= 6'h20;
        @(posedge ref_clk_in);
        tev <= 6'h00;
        irq_chk(1'b1);
        wr(IDX_GATE, 16'h0000);
        irq_chk(1'b0);
        wr(IDX_GATE, 16'h0001);
        wr(IDX_TX_EN, 16'h0000);
        irq_chk(1'b0);
        wr(IDX_TX_EN, 16'h0020);
        irq_chk(1'b1);
        wr(IDX_TX_LAT, 16'h0020);
        irq_chk(1'b0);
        wr(IDX_TX_EN, 16'h0004);
        tev <= 6'h04;
        @(posedge ref_clk_in);
        tev <= 6'h00;
        irq_chk(1'b1);
        wr(IDX_TX_LAT, 16'h0004);
        irq_chk(1'b0);
        for (int m = 0; m < 4; m++) begin
            ctl = ctl_tab[m];
            wr(IDX_RX_CTRL, ctl);
            src_inv <= ctl[2];
            frame();
            rd_chk("rx_live_held", IDX_RX_LIVE, 16'h0001);
            rd_chk("rx_first", IDX_RX_DATA, {ctl[3] ? 8'h38 : 8'h1C, 8'h03});
            rd_chk("rx_last", IDX_RX_DATA,
                {ctl[3] ? 8'h1F : 8'hF8, ctl[1] ? 8'h09 : 8'h0B});
            rd_chk("rx_live_empty", IDX_RX_LIVE, 16'h0003);
        end
        rd_chk("rx_latch", IDX_RX_LAT, 16'h0019);
        wr(IDX_RX_EN, 16'h0010);
        irq_chk(1'b1);
        wr(IDX_RX_LAT, 16'h0019);
        irq_chk(1'b0);
        wr(IDX_RX_CTRL, 16'h0003);
        irq_chk(1'b0);
        chk("power_down", 16'h0001, {15'h0000, pd});
        rd_chk("rx_live_clr", IDX_RX_LIVE, 16'h0002);
        frame();
        wr(IDX_RX_CTRL, 16'h0002);
        irq_chk(1'b0);
        chk("power_up", 16'h0000, {15'h0000, pd});
        rd_chk("rx_live_disc", IDX_RX_LIVE, 16'h0003);
        end_sim();
    end
endmodule
